// ### dv/ckgen_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module ckgen_analog_model (
	input  wire logic oscEnable,
	input  wire logic osc_bypass_sel,
	input  wire logic pllAOn,
	input  wire logic pllBOn,
	output logic      slowClkIn,
	output logic      mainClkIn,
	output logic      pllAClkIn,
	output logic      pllBClkIn
);
	logic xtal = 1'b0;
	logic a = 1'b0;
	logic b = 1'b0;
	initial slowClkIn = 1'b0;
	always #100 slowClkIn = ~slowClkIn;
	always #40 xtal = ~xtal;
	// Cells slower than real so sampled dividers follow exactly
	always #60 a = ~a;
	always #80 b = ~b;
	// Dead oscillator or cell stands at zero
	assign mainClkIn = (oscEnable | osc_bypass_sel) & xtal;
	assign pllAClkIn = pllAOn & a;
	assign pllBClkIn = pllBOn & b;
endmodule : ckgen_analog_model
`default_nettype wire

// ### dv/ckgen_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module ckgen_top_props (
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic [7:0]  regAddr,
	input wire logic [31:0] regWrData,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [31:0] regRdData,
	input wire logic        oscEnable,
	input wire logic        osc_bypass_sel,
	input wire logic        pllAOn,
	input wire logic [7:0]  pllAMul,
	input wire logic        pllBOn,
	input wire logic [5:0]  pllBMul
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	sequence sWrOsc;
		regWr && regAddr == ckgen_pkg::OFS_OSC_CTRL;
	endsequence
	sequence sRdSt;
		regRd && regAddr == ckgen_pkg::OFS_STATUS;
	endsequence
	sequence sWrMck;
		regWr && regAddr == ckgen_pkg::OFS_MASTER;
	endsequence
	AST_RD_IDLE: assert property (!$past(regRd) |-> regRdData == 32'h0)
		else $error("Read data not zero outside read slot");
	AST_OSC_EN: assert property (sWrOsc |-> ##2 oscEnable == $past(regWrData[0], 2))
		else $error("Oscillator enable does not follow write");
	AST_OSC_BYP: assert property (sWrOsc |-> ##2 osc_bypass_sel == $past(regWrData[1], 2))
		else $error("Bypass does not follow write");
	AST_STB_CLR: assert property ((!oscEnable && !osc_bypass_sel)[*2] ##0 sRdSt |=> !regRdData[0])
		else $error("Stable flag set while oscillator off");
	AST_STB_BYP: assert property (osc_bypass_sel[*2] ##0 sRdSt |=> regRdData[0])
		else $error("Stable flag clear while bypassed");
	AST_PLLA: assert property (regWr && regAddr == ckgen_pkg::OFS_PLL_A |-> ##2
		pllAOn == ($past(regWrData[23:16], 2) != 8'h00) &&
		pllAMul == $past(regWrData[23:16], 2))
		else $error("PLL A multiplier output wrong");
	AST_PLLB: assert property (regWr && regAddr == ckgen_pkg::OFS_PLL_B |-> ##2
		pllBOn == ($past(regWrData[21:16], 2) != 6'h00) &&
		pllBMul == $past(regWrData[21:16], 2))
		else $error("PLL B multiplier output wrong");
	AST_PROCESSOR_DIVIDER: assert property (regRd && regAddr == ckgen_pkg::OFS_MASTER |=>
		!(regRdData[12] && regRdData[9:8] == 2'h0))
		else $error("Processor divide bit set with master divider zero");
	AST_MCK_RDY: assert property (sWrMck ##[2:4] sRdSt |=> !regRdData[3])
		else $error("Master ready high right after clock change");
endmodule : ckgen_top_props
bind ckgen_top ckgen_top_props ckgen_top_props_inst (.*);
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [31:0] regRdData, d;
	logic        slowClkIn, mainClkIn, pllAClkIn, pllBClkIn, oscEnable, osc_bypass_sel;
	logic        pllARef, pllAOn, pllBRef, pllBOn, usbClk, masterClk, procClk;
	logic [7:0]  pllAMul;
	logic [5:0]  pllBMul;
	logic [1:0]  pllARange, pllBRange, progClk;
	logic [6:0]  mon;
	int          fail_count = 0;
	int          cmp_count = 0;
	int          n;
	int          src[4] = '{60, 150, 100, 75};
	int          dv[4] = '{1, 2, 4, 6};
	assign mon = {progClk, pllBRef, pllARef, procClk, masterClk, usbClk};
	initial forever #5 clk_sys = ~clk_sys;
	ckgen_top ckgen_top_inst (.*);
	ckgen_analog_model ckgen_analog_model_inst (.*);
	task automatic conclude;
		$display("Compared %0d, mismatched %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask : cmp
	task automatic near(input string nm, input int e, input int t, input logic [31:0] g);
		logic signed [32:0] s;
		s = $signed({1'b0, g});
		cmp_count++;
		if ((s >= e - t && s <= e + t) !== 1'b1)
		begin
			fail_count++;
			$display("[FAIL] %s expected %0d seen %0d", nm, e, g);
		end
	endtask : near
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= v;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 v = regRdData;
	endtask : rd
	// Polls a flag; a read costs two cycles
	task automatic waitBit(input logic [7:0] a, input int b, output int c);
		c = 0;
		d = 32'h0;
		while (d[b] !== 1'b1)
		begin
			rd(a, d);
			c += 2;
			if (c > 2000)
			begin
				fail_count++;
				conclude();
			end
		end
	endtask : waitBit
	task automatic waitFall;
		int k;
		for (k = 0; k < 40 && !slowClkIn; k++)
			@(posedge clk_sys);
		for (k = k; k < 40 && slowClkIn; k++)
			@(posedge clk_sys);
		if (k >= 40)
		begin
			fail_count++;
			conclude();
		end
	endtask : waitFall
	task automatic cnt(input int sel, output int r);
		logic p;
		r = 0;
		p = mon[sel];
		repeat (1200)
		begin
			@(posedge clk_sys);
			#1 r += (mon[sel] && !p) ? 1 : 0;
			p = mon[sel];
		end
	endtask : cnt
	initial
	begin
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(ckgen_pkg::OFS_STATUS, d);
		cmp("status reset", 32'h08, d);
		rd(ckgen_pkg::OFS_PLL_B, d);
		cmp("pll B reset", 32'h3F00, d);
		wr(8'h00, 32'hFFFFFFFF);
		rd(8'h00, d);
		cmp("unmapped", 32'h0, d);
		$display("Test reset done");
		waitFall();
		wr(ckgen_pkg::OFS_OSC_CTRL, 32'h0201);
		waitBit(ckgen_pkg::OFS_STATUS, 0, n);
		near("start-up", 312, 6, n);
		waitBit(ckgen_pkg::OFS_FREQ_MEAS, 16, n);
		near("freq count", 40, 1, d & 32'hFFFF);
		wr(ckgen_pkg::OFS_OSC_CTRL, 32'h0);
		rd(ckgen_pkg::OFS_STATUS, d);
		cmp("stable off", 32'h0, d & 32'h1);
		rd(ckgen_pkg::OFS_FREQ_MEAS, d);
		cmp("freq valid off", 32'h0, d & 32'h10000);
		wr(ckgen_pkg::OFS_OSC_CTRL, 32'h2);
		rd(ckgen_pkg::OFS_STATUS, d);
		cmp("stable bypass", 32'h1, d & 32'h1);
		$display("Test oscillator done");
		waitFall();
		wr(ckgen_pkg::OFS_PLL_A, 32'h20044301);
		waitBit(ckgen_pkg::OFS_STATUS, 1, n);
		near("lock A", 52, 6, n);
		rd(ckgen_pkg::OFS_PLL_A, d);
		cmp("pll A", 32'h20044301, d);
		waitFall();
		wr(ckgen_pkg::OFS_PLL_B, 32'h0003C201);
		waitBit(ckgen_pkg::OFS_STATUS, 2, n);
		near("lock B", 32, 6, n);
		cmp("ranges", 32'h7, {pllARange, pllBRange});
		for (int i = 0; i < 3; i++)
		begin
			wr(ckgen_pkg::OFS_PLL_A, 32'h20040300 | i);
			cnt(3, n);
			near("ref A", i == 0 ? 0 : 150 / i, 2, n);
			wr(ckgen_pkg::OFS_PLL_B, 32'h00030200 | i);
			cnt(4, n);
			near("ref B", i == 0 ? 0 : 150 / i, 2, n);
			wr(ckgen_pkg::OFS_PLL_B, 32'h00030201 | (i << 28));
			cnt(0, n);
			near("usb", 75 >> i, 2, n);
		end
		$display("Test pll done");
		for (int i = 0; i < 4; i++)
		begin
			wr(ckgen_pkg::OFS_MASTER, i);
			cnt(1, n);
			near("master src", src[i], 2, n);
			wr(ckgen_pkg::OFS_MASTER, 32'h1 | (i << 8));
			cnt(1, n);
			near("master div", 150 / dv[i], 2, n);
		end
		for (int i = 0; i < 7; i++)
		begin
			wr(ckgen_pkg::OFS_MASTER, 32'h1 | (i << 2));
			cnt(1, n);
			near("master prescale_select", 150 >> i, 2, n);
			wr(ckgen_pkg::OFS_PROG_BASE, 32'h1 | (i << 2));
			cnt(5, n);
			near("prog prescale_select", 150 >> i, 2, n);
		end
		wr(ckgen_pkg::OFS_MASTER, 32'h1201);
		cnt(2, n);
		near("proc half", 75, 2, n);
		wr(ckgen_pkg::OFS_MASTER, 32'h1001);
		rd(ckgen_pkg::OFS_MASTER, d);
		cmp("processor_divider forced", 32'h1, d);
		rd(ckgen_pkg::OFS_STATUS, d);
		cmp("ready low", 32'h0, d & 32'h8);
		waitBit(ckgen_pkg::OFS_STATUS, 3, n);
		$display("Test master done");
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 4; i++)
			begin
				wr(ckgen_pkg::OFS_PROG_BASE + 8'(p * 4), 32'h4 | i);
				cnt(5 + p, n);
				near("prog src", src[i] / 2, 2, n);
			end
		wr(ckgen_pkg::OFS_PLL_A, 32'h20000301);
		wr(ckgen_pkg::OFS_MASTER, 32'h2);
		cnt(1, n);
		near("pll A off", 0, 0, n);
		$display("Test prog done");
		conclude();
	end
endmodule : tb_top
`default_nettype wire

// ### verilog/ckgen_pkg.sv
`default_nettype none
package ckgen_pkg;
	// Register byte addresses
	localparam logic [7:0] OFS_OSC_CTRL   = 8'h20;
	localparam logic [7:0] OFS_FREQ_MEAS  = 8'h24;
	localparam logic [7:0] OFS_PLL_A      = 8'h28;
	localparam logic [7:0] OFS_PLL_B      = 8'h2C;
	localparam logic [7:0] OFS_MASTER     = 8'h30;
	localparam logic [7:0] OFS_PROG_BASE  = 8'h40;
	localparam logic [7:0] OFS_PROG_STEP  = 8'h04;
	localparam logic [7:0] OFS_STATUS     = 8'h68;
	// Field positions
	localparam int OSC_EN_BIT     = 0;
	localparam int OSC_BYP_BIT    = 1;
	localparam int OSC_CNT_LSB    = 8;
	localparam int FREQ_RDY_BIT   = 16;
	localparam int PLL_DIV_LSB    = 0;
	localparam int PLL_CNT_LSB    = 8;
	localparam int PLL_RANGE_LSB  = 14;
	localparam int PLL_MUL_LSB    = 16;
	localparam int PLLA_FIX_BIT   = 29;
	localparam int PLLB_USB_LSB   = 28;
	localparam int CLK_CSS_LSB    = 0;
	localparam int CLK_PRESCALE_SELECT_LSB   = 2;
	localparam int MCK_MASTER_DIVIDER_LSB   = 8;
	localparam int MCK_PROCESSOR_DIVIDER_BIT   = 12;
	localparam int SR_STABLE_BIT  = 0;
	localparam int SR_PLL_A_LOCKED_FLAG_BIT   = 1;
	localparam int SR_PLL_B_LOCKED_FLAG_BIT   = 2;
	localparam int SR_MCKRDY_BIT  = 3;
	localparam int SR_PCKRDY_LSB  = 8;
	// Pin sampler lanes
	localparam int PIN_SLOW = 0;
	localparam int PIN_MAIN = 1;
	localparam int PIN_PLLA = 2;
	localparam int PIN_PLLB = 3;
	// Reset values and timing
	localparam logic [5:0] PLLB_CNT_RST   = 6'h3F;
	localparam int         STARTUP_SHIFT  = 3;
	localparam logic [4:0] FREQ_WINDOW    = 5'h10;
	localparam logic [1:0] RDY_EDGES      = 2'h2;
	localparam logic [2:0] PRESCALE_SELECT_RESERVED  = 3'h7;
	localparam logic [1:0] USB_RESERVED   = 2'h3;
	localparam logic [1:0] MASTER_DIVIDER_SIX       = 2'h3;
	localparam logic [8:0] DIV_SIX        = 9'h006;

	typedef struct packed {
		logic [7:0] startupCount;
		logic       oscBypassSel;
		logic       oscEnable;
	} ckgen_osc_s;

	typedef struct packed {
		logic       fixedOne;
		logic [7:0] multiplier;
		logic [1:0] range;
		logic [5:0] lockDelay;
		logic [7:0] preDivider;
	} ckgen_plla_s;

	typedef struct packed {
		logic [1:0] usbClockDivider;
		logic [5:0] multiplier;
		logic [1:0] range;
		logic [5:0] lockDelay;
		logic [7:0] preDivider;
	} ckgen_pllb_s;

	typedef struct packed {
		logic       processorDivider;
		logic [1:0] masterDivider;
		logic [2:0] prescaleSelect;
		logic [1:0] clockSourceSelect;
	} ckgen_mck_s;

	typedef struct packed {
		logic [2:0] prescaleSelect;
		logic [1:0] clockSourceSelect;
	} ckgen_pck_s;

	typedef enum logic [1:0] {FM_IDLE, FM_ARM, FM_COUNT, FM_DONE} ckgen_fm_e;
endpackage : ckgen_pkg
`default_nettype wire

// ### verilog/ckgen_top.sv
// Notes on behaviour
// - Enable bit starts the crystal oscillator; bypass must be zero meanwhile; clearing stops it.
// - With bypass zero, the stable flag rises only after the programmed start-up time from enabling.
// - Bypass routes external clock on crystal input and sets stable flag at once.
// - With enable and bypass both zero, the stable flag clears.
// - Start-up time is start-up count times eight slow clock cycles.
// - Frequency field counts main cycles in 16 slow periods; bit 16 flags validity.
// - PLL A pre-divider: 0 gives zero, 1 passes main clock, 2-255 divide.
// - PLL A lock flag sets after programmed slow cycles following any write.
// - PLL A multiplier zero disables it; 1-254 multiply input by value plus one.
// - PLL B pre-divider: 0 gives zero, 1 bypasses, 2-255 divide input.
// - PLL B lock flag sets after programmed slow cycles following any write.
// - PLL B multiplier zero disables it; 1-62 multiply input by value plus one.
// - USB divider passes PLL B output, halves it, or quarters it; 11 reserved.
// - Master source select picks slow, main, PLL A or PLL B clock.
// - Master prescaler divides by 1 to 64 in powers of two; 111 reserved.
// - Master divider takes prescaler output divided by 1, 2, 4 or 6.
// - Processor clock is prescaler output, or half of it when bit set.
// - Writing master divider zero forces processor divide bit to zero.
// - Each programmable output picks slow, main, PLL A or PLL B clock.
// - Each programmable output divides its source by 1 to 64; 111 reserved.
// - Stable flag reads one once the main oscillator has stabilised or bypass is set, else zero.
`timescale 1ns/1ps
`default_nettype none

module ckgen_div #(
	parameter int W = 9
) (
	input  wire logic         clk,
	input  wire logic         rstSyncN,
	input  wire logic         restart,
	input  wire logic         srcLvl,
	input  wire logic [W-1:0] divisor,
	output logic              divLvl
);
	logic         srcPrev_r;
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	always_comb
	begin
		cnt_nxt = (cnt_r >= divisor - W'(1)) ? '0 : cnt_r + W'(1);
	end

	always_ff @(posedge clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			srcPrev_r <= 1'b0;
			cnt_r     <= '0;
			divLvl    <= 1'b0;
		end
		else
		begin
			srcPrev_r <= srcLvl;
			if (restart)
			begin
				cnt_r  <= '0;
				divLvl <= 1'b0;
			end
			else if (divisor == '0)
				divLvl <= 1'b0;
			else if (divisor == W'(1))
				divLvl <= srcLvl;
			else if (srcLvl && !srcPrev_r)
			begin
				cnt_r  <= cnt_nxt;
				divLvl <= (cnt_nxt < (divisor >> 1));
			end
		end
	end
endmodule : ckgen_div

module ckgen_top #(
	parameter int NUM_PCK = 2
) (
	input  wire logic               clk_sys,
	input  wire logic               rstn,
	input  wire logic [7:0]         regAddr,
	input  wire logic [31:0]        regWrData,
	input  wire logic               regWr,
	input  wire logic               regRd,
	output logic      [31:0]        regRdData,
	input  wire logic               slowClkIn,
	input  wire logic               mainClkIn,
	input  wire logic               pllAClkIn,
	input  wire logic               pllBClkIn,
	output logic                    oscEnable,
	output logic                    osc_bypass_sel,
	output logic                    pllARef,
	output logic                    pllAOn,
	output logic      [7:0]         pllAMul,
	output logic      [1:0]         pllARange,
	output logic                    pllBRef,
	output logic                    pllBOn,
	output logic      [5:0]         pllBMul,
	output logic      [1:0]         pllBRange,
	output logic                    usbClk,
	output logic                    masterClk,
	output logic                    procClk,
	output logic      [NUM_PCK-1:0] progClk
);
	function automatic logic srcPick(input logic [1:0] clock_source_select, input logic [3:0] lvl);
		return lvl[clock_source_select];
	endfunction : srcPick

	function automatic logic [8:0] presDiv(input logic [2:0] code);
		// Reserved code behaves as pass-through
		return (code == ckgen_pkg::PRESCALE_SELECT_RESERVED) ? 9'h001 : (9'h001 << code);
	endfunction : presDiv

	logic                    rst_r0;
	logic                    rstSyncN;
	logic [3:0]              pinMeta_r;
	logic [3:0]              pinSync_r;
	logic [1:0]              pinDly_r;
	logic                    slowRise;
	logic                    mainRise;
	logic [3:0]              srcLvl;
	ckgen_pkg::ckgen_osc_s   osc_r;
	ckgen_pkg::ckgen_plla_s  pllA_r;
	ckgen_pkg::ckgen_pllb_s  pllB_r;
	ckgen_pkg::ckgen_mck_s   mck_r;
	ckgen_pkg::ckgen_pck_s   pck_r [NUM_PCK];
	logic                    wrOsc;
	logic                    wrMck;
	logic [1:0]              wrPll;
	logic [NUM_PCK-1:0]      wrPck;
	logic                    oscEnPrev_r;
	logic [10:0]             startCnt_r;
	logic                    oscStable_r;
	ckgen_pkg::ckgen_fm_e    fmState_r;
	logic [4:0]              fmWin_r;
	logic [15:0]             fmCnt_r;
	logic [15:0]             mainFreqCount_r;
	logic                    freqCountValid_r;
	logic [5:0]              lockCnt_r [2];
	logic [1:0]              locked_r;
	logic                    presLvl;
	logic [8:0]              mdivVal;
	logic                    mckPrev_r;
	logic [1:0]              mckWait_r;
	logic                    mckRdy_r;
	logic [NUM_PCK-1:0]      pckRdy_r;
	logic [31:0]             rdWord;

	// Reset release through two flops
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_r0   <= 1'b0;
			rstSyncN <= 1'b0;
		end
		else
		begin
			rst_r0   <= 1'b1;
			rstSyncN <= rst_r0;
		end
	end

	// Clock pins are asynchronous levels; first stage feeds only the second
	always_ff @(posedge clk_sys or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			pinMeta_r <= 4'h0;
			pinSync_r <= 4'h0;
			pinDly_r  <= 2'h0;
		end
		else
		begin
			pinMeta_r <= {pllBClkIn, pllAClkIn, mainClkIn, slowClkIn};
			pinSync_r <= pinMeta_r;
			pinDly_r  <= pinSync_r[1:0];
		end
	end

	assign slowRise = pinSync_r[ckgen_pkg::PIN_SLOW] && !pinDly_r[ckgen_pkg::PIN_SLOW];
	assign mainRise = pinSync_r[ckgen_pkg::PIN_MAIN] && !pinDly_r[ckgen_pkg::PIN_MAIN];

	// Source order matches the 2-bit select codes
	assign srcLvl[0] = pinSync_r[ckgen_pkg::PIN_SLOW];
	assign srcLvl[1] = pinSync_r[ckgen_pkg::PIN_MAIN] && oscStable_r;
	assign srcLvl[2] = pinSync_r[ckgen_pkg::PIN_PLLA] && pllAOn;
	assign srcLvl[3] = pinSync_r[ckgen_pkg::PIN_PLLB] && pllBOn;

	assign wrOsc    = regWr && (regAddr == ckgen_pkg::OFS_OSC_CTRL);
	assign wrPll[0] = regWr && (regAddr == ckgen_pkg::OFS_PLL_A);
	assign wrPll[1] = regWr && (regAddr == ckgen_pkg::OFS_PLL_B);
	assign wrMck    = regWr && (regAddr == ckgen_pkg::OFS_MASTER);

	always_ff @(posedge clk_sys or negedge rstSyncN)
	begin
		if (!rstSyncN)
			osc_r <= '0;
		else if (wrOsc)
		begin
			osc_r.oscEnable    <= regWrData[ckgen_pkg::OSC_EN_BIT];
			osc_r.oscBypassSel <= regWrData[ckgen_pkg::OSC_BYP_BIT];
			osc_r.startupCount <= regWrData[ckgen_pkg::OSC_CNT_LSB +: 8];
		end
	end

	always_ff @(posedge clk_sys or negedge rstSyncN)
	begin
		if (!rstSyncN)
			pllA_r <= '0;
		else if (wrPll[0])
		begin
			pllA_r.preDivider <= regWrData[ckgen_pkg::PLL_DIV_LSB +: 8];
			pllA_r.lockDelay  <= regWrData[ckgen_pkg::PLL_CNT_LSB +: 6];
			pllA_r.range      <= regWrData[ckgen_pkg::PLL_RANGE_LSB +: 2];
			pllA_r.multiplier <= regWrData[ckgen_pkg::PLL_MUL_LSB +: 8];
			pllA_r.fixedOne   <= regWrData[ckgen_pkg::PLLA_FIX_BIT];
		end
	end

	always_ff @(posedge clk_sys or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			pllB_r           <= '0;
			pllB_r.lockDelay <= ckgen_pkg::PLLB_CNT_RST;
		end
		else if (wrPll[1])
		begin
			pllB_r.preDivider      <= regWrData[ckgen_pkg::PLL_DIV_LSB +: 8];
			pllB_r.lockDelay       <= regWrData[ckgen_pkg::PLL_CNT_LSB +: 6];
			pllB_r.range           <= regWrData[ckgen_pkg::PLL_RANGE_LSB +: 2];
			pllB_r.multiplier      <= regWrData[ckgen_pkg::PLL_MUL_LSB +: 6];
			pllB_r.usbClockDivider <= regWrData[ckgen_pkg::PLLB_USB_LSB +: 2];
		end
	end

	always_ff @(posedge clk_sys or negedge rstSyncN)
	begin
		if (!rstSyncN)
			mck_r <= '0;
		else if (wrMck)
		begin
			mck_r.clockSourceSelect <= regWrData[ckgen_pkg::CLK_CSS_LSB +: 2];
			mck_r.prescaleSelect    <= regWrData[ckgen_pkg::CLK_PRESCALE_SELECT_LSB +: 3];
			mck_r.masterDivider     <= regWrData[ckgen_pkg::MCK_MASTER_DIVIDER_LSB +: 2];
			mck_r.processorDivider  <= (regWrData[ckgen_pkg::MCK_MASTER_DIVIDER_LSB +: 2] == 2'h0) ?
				1'b0 : regWrData[ckgen_pkg::MCK_PROCESSOR_DIVIDER_BIT];
		end
	end

	// Analog-facing controls, held in flops
	always_ff @(posedge clk_sys or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			oscEnable <= 1'b0;
			osc_bypass_sel <= 1'b0;
			pllAOn    <= 1'b0;
			pllAMul   <= 8'h00;
			pllARange <= 2'h0;
			pllBOn    <= 1'b0;
			pllBMul   <= 6'h00;
			pllBRange <= 2'h0;
		end
		else
		begin
			oscEnable <= osc_r.oscEnable;
			osc_bypass_sel <= osc_r.oscBypassSel;
			pllAOn    <= (pllA_r.multiplier != 8'h00);
			pllAMul   <= pllA_r.multiplier;
			pllARange <= pllA_r.range;
			pllBOn    <= (pllB_r.multiplier != 6'h00);
			pllBMul   <= pllB_r.multiplier;
			pllBRange <= pllB_r.range;
		end
	end

	// Start-up timer on the slow clock
	always_ff @(posedge clk_sys or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			oscEnPrev_r <= 1'b0;
			startCnt_r  <= '0;
			oscStable_r <= 1'b0;
		end
		else
		begin
			oscEnPrev_r <= osc_r.oscEnable;
			if (!osc_r.oscEnable && !osc_r.oscBypassSel)
			begin
				startCnt_r  <= '0;
				oscStable_r <= 1'b0;
			end
			else if (osc_r.oscBypassSel)
				oscStable_r <= 1'b1;
			else if (!oscEnPrev_r)
			begin
				startCnt_r  <= {osc_r.startupCount, 3'b000};
				oscStable_r <= (osc_r.startupCount == 8'h00);
			end
			else if (!oscStable_r && slowRise)
			begin
				startCnt_r <= startCnt_r - 11'h001;
				if (startCnt_r <= 11'h001)
					oscStable_r <= 1'b1;
			end
		end
	end

	// One measurement per oscillator start; valid flag cleared when it stops, count kept
	always_ff @(posedge clk_sys or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			fmState_r        <= ckgen_pkg::FM_IDLE;
			fmWin_r          <= '0;
			fmCnt_r          <= '0;
			mainFreqCount_r  <= '0;
			freqCountValid_r <= 1'b0;
		end
		else if (!oscStable_r)
		begin
			fmState_r        <= ckgen_pkg::FM_IDLE;
			freqCountValid_r <= 1'b0;
		end
		else
		begin
			unique case (fmState_r)
				ckgen_pkg::FM_IDLE:
					fmState_r <= ckgen_pkg::FM_ARM;
				ckgen_pkg::FM_ARM:
					if (slowRise)
					begin
						fmState_r <= ckgen_pkg::FM_COUNT;
						fmWin_r   <= '0;
						fmCnt_r   <= '0;
					end
				ckgen_pkg::FM_COUNT:
				begin
					if (mainRise)
						fmCnt_r <= fmCnt_r + 16'h0001;
					if (slowRise)
					begin
						fmWin_r <= fmWin_r + 5'h01;
						if (fmWin_r + 5'h01 == ckgen_pkg::FREQ_WINDOW)
						begin
							fmState_r        <= ckgen_pkg::FM_DONE;
							mainFreqCount_r  <= fmCnt_r + {15'h0000, mainRise};
							freqCountValid_r <= 1'b1;
						end
					end
				end
				ckgen_pkg::FM_DONE:
					fmState_r <= ckgen_pkg::FM_DONE;
			endcase
		end
	end

	// A new write restarts the lock wait, so the write beats a pending lock
	for (genvar p = 0; p < 2; p++)
	begin : g_lock
		always_ff @(posedge clk_sys or negedge rstSyncN)
		begin
			if (!rstSyncN)
			begin
				lockCnt_r[p] <= '0;
				locked_r[p]  <= 1'b0;
			end
			else if (wrPll[p])
			begin
				lockCnt_r[p] <= regWrData[ckgen_pkg::PLL_CNT_LSB +: 6];
				locked_r[p]  <= (regWrData[ckgen_pkg::PLL_CNT_LSB +: 6] == 6'h00);
			end
			else if (!locked_r[p] && slowRise)
			begin
				lockCnt_r[p] <= lockCnt_r[p] - 6'h01;
				if (lockCnt_r[p] <= 6'h01)
					locked_r[p] <= 1'b1;
			end
		end
	end

	ckgen_div #(.W(9)) u_pll_a_pre_divider (
		.clk      (clk_sys),
		.rstSyncN (rstSyncN),
		.restart  (wrPll[0]),
		.srcLvl   (srcLvl[1]),
		.divisor  ({1'b0, pllA_r.preDivider}),
		.divLvl   (pllARef)
	);

	ckgen_div #(.W(9)) u_pll_b_pre_divider (
		.clk      (clk_sys),
		.rstSyncN (rstSyncN),
		.restart  (wrPll[1]),
		.srcLvl   (srcLvl[1]),
		.divisor  ({1'b0, pllB_r.preDivider}),
		.divLvl   (pllBRef)
	);

	ckgen_div #(.W(9)) u_usb (
		.clk      (clk_sys),
		.rstSyncN (rstSyncN),
		.restart  (wrPll[1]),
		.srcLvl   (srcLvl[3]),
		.divisor  ((pllB_r.usbClockDivider == ckgen_pkg::USB_RESERVED) ? 9'h001 :
			(9'h001 << pllB_r.usbClockDivider)),
		.divLvl   (usbClk)
	);

	ckgen_div #(.W(9)) u_prescale_select (
		.clk      (clk_sys),
		.rstSyncN (rstSyncN),
		.restart  (wrMck),
		.srcLvl   (srcPick(mck_r.clockSourceSelect, srcLvl)),
		.divisor  (presDiv(mck_r.prescaleSelect)),
		.divLvl   (presLvl)
	);

	assign mdivVal = (mck_r.masterDivider == ckgen_pkg::MASTER_DIVIDER_SIX) ? ckgen_pkg::DIV_SIX :
		(9'h001 << mck_r.masterDivider);

	ckgen_div #(.W(9)) u_master_divider (
		.clk      (clk_sys),
		.rstSyncN (rstSyncN),
		.restart  (wrMck),
		.srcLvl   (presLvl),
		.divisor  (mdivVal),
		.divLvl   (masterClk)
	);

	ckgen_div #(.W(9)) u_processor_divider (
		.clk      (clk_sys),
		.rstSyncN (rstSyncN),
		.restart  (wrMck),
		.srcLvl   (presLvl),
		.divisor  ({8'h00, mck_r.processorDivider} + 9'h001),
		.divLvl   (procClk)
	);

	// Dividers restart on a write, so ready waits for fresh edges
	always_ff @(posedge clk_sys or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			mckPrev_r <= 1'b0;
			mckWait_r <= '0;
			mckRdy_r  <= 1'b1;
		end
		else
		begin
			mckPrev_r <= masterClk;
			if (wrMck)
			begin
				mckWait_r <= '0;
				mckRdy_r  <= 1'b0;
			end
			else if (!mckRdy_r && masterClk && !mckPrev_r)
			begin
				mckWait_r <= mckWait_r + 2'h1;
				if (mckWait_r + 2'h1 == ckgen_pkg::RDY_EDGES)
					mckRdy_r <= 1'b1;
			end
		end
	end

	for (genvar i = 0; i < NUM_PCK; i++)
	begin : g_pck
		logic       pckPrev_r;
		logic [1:0] pckWait_r;

		assign wrPck[i] = regWr &&
			(regAddr == ckgen_pkg::OFS_PROG_BASE + 8'(i) * ckgen_pkg::OFS_PROG_STEP);

		always_ff @(posedge clk_sys or negedge rstSyncN)
		begin
			if (!rstSyncN)
				pck_r[i] <= '0;
			else if (wrPck[i])
			begin
				pck_r[i].clockSourceSelect <= regWrData[ckgen_pkg::CLK_CSS_LSB +: 2];
				pck_r[i].prescaleSelect    <= regWrData[ckgen_pkg::CLK_PRESCALE_SELECT_LSB +: 3];
			end
		end

		ckgen_div #(.W(9)) u_pck (
			.clk      (clk_sys),
			.rstSyncN (rstSyncN),
			.restart  (wrPck[i]),
			.srcLvl   (srcPick(pck_r[i].clockSourceSelect, srcLvl)),
			.divisor  (presDiv(pck_r[i].prescaleSelect)),
			.divLvl   (progClk[i])
		);

		always_ff @(posedge clk_sys or negedge rstSyncN)
		begin
			if (!rstSyncN)
			begin
				pckPrev_r   <= 1'b0;
				pckWait_r   <= '0;
				pckRdy_r[i] <= 1'b0;
			end
			else
			begin
				pckPrev_r <= progClk[i];
				if (wrPck[i])
				begin
					pckWait_r   <= '0;
					pckRdy_r[i] <= 1'b0;
				end
				else if (!pckRdy_r[i] && progClk[i] && !pckPrev_r)
				begin
					pckWait_r <= pckWait_r + 2'h1;
					if (pckWait_r + 2'h1 == ckgen_pkg::RDY_EDGES)
						pckRdy_r[i] <= 1'b1;
				end
			end
		end
	end

	always_comb
	begin
		rdWord = 32'h0000_0000;
		if (regAddr == ckgen_pkg::OFS_OSC_CTRL)
		begin
			rdWord[ckgen_pkg::OSC_EN_BIT]        = osc_r.oscEnable;
			rdWord[ckgen_pkg::OSC_BYP_BIT]       = osc_r.oscBypassSel;
			rdWord[ckgen_pkg::OSC_CNT_LSB +: 8]  = osc_r.startupCount;
		end
		else if (regAddr == ckgen_pkg::OFS_FREQ_MEAS)
		begin
			rdWord[15:0]                        = mainFreqCount_r;
			rdWord[ckgen_pkg::FREQ_RDY_BIT]     = freqCountValid_r;
		end
		else if (regAddr == ckgen_pkg::OFS_PLL_A)
		begin
			rdWord[ckgen_pkg::PLL_DIV_LSB +: 8]   = pllA_r.preDivider;
			rdWord[ckgen_pkg::PLL_CNT_LSB +: 6]   = pllA_r.lockDelay;
			rdWord[ckgen_pkg::PLL_RANGE_LSB +: 2] = pllA_r.range;
			rdWord[ckgen_pkg::PLL_MUL_LSB +: 8]   = pllA_r.multiplier;
			rdWord[ckgen_pkg::PLLA_FIX_BIT]       = pllA_r.fixedOne;
		end
		else if (regAddr == ckgen_pkg::OFS_PLL_B)
		begin
			rdWord[ckgen_pkg::PLL_DIV_LSB +: 8]   = pllB_r.preDivider;
			rdWord[ckgen_pkg::PLL_CNT_LSB +: 6]   = pllB_r.lockDelay;
			rdWord[ckgen_pkg::PLL_RANGE_LSB +: 2] = pllB_r.range;
			rdWord[ckgen_pkg::PLL_MUL_LSB +: 6]   = pllB_r.multiplier;
			rdWord[ckgen_pkg::PLLB_USB_LSB +: 2]  = pllB_r.usbClockDivider;
		end
		else if (regAddr == ckgen_pkg::OFS_MASTER)
		begin
			rdWord[ckgen_pkg::CLK_CSS_LSB +: 2]  = mck_r.clockSourceSelect;
			rdWord[ckgen_pkg::CLK_PRESCALE_SELECT_LSB +: 3] = mck_r.prescaleSelect;
			rdWord[ckgen_pkg::MCK_MASTER_DIVIDER_LSB +: 2] = mck_r.masterDivider;
			rdWord[ckgen_pkg::MCK_PROCESSOR_DIVIDER_BIT]      = mck_r.processorDivider;
		end
		else if (regAddr == ckgen_pkg::OFS_STATUS)
		begin
			rdWord[ckgen_pkg::SR_STABLE_BIT]               = oscStable_r;
			rdWord[ckgen_pkg::SR_PLL_A_LOCKED_FLAG_BIT]                = locked_r[0];
			rdWord[ckgen_pkg::SR_PLL_B_LOCKED_FLAG_BIT]                = locked_r[1];
			rdWord[ckgen_pkg::SR_MCKRDY_BIT]               = mckRdy_r;
			rdWord[ckgen_pkg::SR_PCKRDY_LSB +: NUM_PCK]    = pckRdy_r;
		end
		else
		begin
			for (int k = 0; k < NUM_PCK; k++)
			begin
				if (regAddr == ckgen_pkg::OFS_PROG_BASE + 8'(k) * ckgen_pkg::OFS_PROG_STEP)
				begin
					rdWord[ckgen_pkg::CLK_CSS_LSB +: 2]  = pck_r[k].clockSourceSelect;
					rdWord[ckgen_pkg::CLK_PRESCALE_SELECT_LSB +: 3] = pck_r[k].prescaleSelect;
				end
			end
		end
	end

	// Read data lives for exactly one cycle after the strobe
	always_ff @(posedge clk_sys or negedge rstSyncN)
	begin
		if (!rstSyncN)
			regRdData <= 32'h0000_0000;
		else if (regRd)
			regRdData <= rdWord;
		else
			regRdData <= 32'h0000_0000;
	end
endmodule : ckgen_top
`default_nettype wire
